// ---- hdl/burst_word_crc16_consts.svh ----
`ifndef BURST_WORD_CRC16_CONSTS_SVH
`define BURST_WORD_CRC16_CONSTS_SVH
// Checksum width and preload value at burst start
`define CRC_WIDTH 16
`define CRC_SEED  16'h4ABA
`endif

// ---- hdl/burst_word_crc16_pkg.sv ----
package burst_word_crc16_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [2:0] {
		IDLE  = 3'h1,
		BURST = 3'h2,
		CHECK = 3'h4
	} crc_phase_t;

	// Combinational next checksum from current state and bus word
	function automatic word_t crc_next_f(input word_t crcState,
		input word_t busWord);
		logic [16:1] f;
		word_t       n;
		f[1]  = busWord[0] ^ crcState[15];
		f[2]  = busWord[1] ^ crcState[14];
		f[3]  = busWord[2] ^ crcState[13];
		f[4]  = busWord[3] ^ crcState[12];
		f[5]  = busWord[4] ^ crcState[11] ^ f[1];
		f[6]  = busWord[5] ^ crcState[10] ^ f[2];
		f[7]  = busWord[6] ^ crcState[9] ^ f[3];
		f[8]  = busWord[7] ^ crcState[8] ^ f[4];
		f[9]  = busWord[8] ^ crcState[7] ^ f[5];
		f[10] = busWord[9] ^ crcState[6] ^ f[6];
		f[11] = busWord[10] ^ crcState[5] ^ f[7];
		f[12] = busWord[11] ^ crcState[4] ^ f[1] ^ f[8];
		f[13] = busWord[12] ^ crcState[3] ^ f[2] ^ f[9];
		f[14] = busWord[13] ^ crcState[2] ^ f[3] ^ f[10];
		f[15] = busWord[14] ^ crcState[1] ^ f[4] ^ f[11];
		f[16] = busWord[15] ^ crcState[0] ^ f[5] ^ f[12];
		n[0]  = f[16];
		n[1]  = f[15];
		n[2]  = f[14];
		n[3]  = f[13];
		n[4]  = f[12];
		n[5]  = f[11] ^ f[16];
		n[6]  = f[10] ^ f[15];
		n[7]  = f[9] ^ f[14];
		n[8]  = f[8] ^ f[13];
		n[9]  = f[7] ^ f[12];
		n[10] = f[6] ^ f[11];
		n[11] = f[5] ^ f[10];
		n[12] = f[4] ^ f[9] ^ f[16];
		n[13] = f[3] ^ f[8] ^ f[15];
		n[14] = f[2] ^ f[7] ^ f[14];
		n[15] = f[1] ^ f[6] ^ f[13];
		return n;
	endfunction
endpackage

// ---- hdl/crc_drive_end.sv ----
`timescale 1ns/1ps
//Operation
//- 16-bit register, combinational next value
//- Next bits 5-11 from paired terms
//- Next bits 0-4 and 8-11 defined
//- Next bits 12-15 use three terms
//- Terms 1-4 bus XOR high register
//- Terms 5-8 add register and terms 1-4
//- Terms 14, 15 use chained terms
//- Checksum drives bus bit for bit
//- Same checksum both transfer directions
//- Preload 4ABA at each burst start
//- One update per data strobe edge
//- No update on termination strobe edge
//- Drive flags mismatch at command end
module crc_drive_end
	import burst_word_crc16_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        clkEn,
	// Link
	crc_link_if.drive        link,
	// User side
	input  wire logic        cmdDone,
	output logic      [15:0] crcState,
	output logic             crcError,
	output logic             errorReport
);
`include "burst_word_crc16_consts.svh"
	crc_phase_t  phase;
	word_t       crcNext;
	logic [16:1] term;

	// ****************
	// Feedback terms
	// ****************
	always_comb begin
		term[1]  = link.busWord[0] ^ crcState[15];
		term[2]  = link.busWord[1] ^ crcState[14];
		term[3]  = link.busWord[2] ^ crcState[13];
		term[4]  = link.busWord[3] ^ crcState[12];
		term[5]  = link.busWord[4] ^ crcState[11] ^ term[1];
		term[6]  = link.busWord[5] ^ crcState[10] ^ term[2];
		term[7]  = link.busWord[6] ^ crcState[9] ^ term[3];
		term[8]  = link.busWord[7] ^ crcState[8] ^ term[4];
		term[9]  = link.busWord[8] ^ crcState[7] ^ term[5];
		term[10] = link.busWord[9] ^ crcState[6] ^ term[6];
		term[11] = link.busWord[10] ^ crcState[5] ^ term[7];
		term[12] = link.busWord[11] ^ crcState[4] ^ term[1] ^
			term[8];
		term[13] = link.busWord[12] ^ crcState[3] ^ term[2] ^
			term[9];
		term[14] = link.busWord[13] ^ crcState[2] ^ term[3] ^
			term[10];
		term[15] = link.busWord[14] ^ crcState[1] ^ term[4] ^
			term[11];
		term[16] = link.busWord[15] ^ crcState[0] ^ term[5] ^
			term[12];
	end

	// ****************
	// Next checksum
	// ****************
	always_comb begin
		crcNext[0]  = term[16];
		crcNext[1]  = term[15];
		crcNext[2]  = term[14];
		crcNext[3]  = term[13];
		crcNext[4]  = term[12];
		crcNext[5]  = term[11] ^ term[16];
		crcNext[6]  = term[10] ^ term[15];
		crcNext[7]  = term[9] ^ term[14];
		crcNext[8]  = term[8] ^ term[13];
		crcNext[9]  = term[7] ^ term[12];
		crcNext[10] = term[6] ^ term[11];
		crcNext[11] = term[5] ^ term[10];
		crcNext[12] = term[4] ^ term[9] ^ term[16];
		crcNext[13] = term[3] ^ term[8] ^ term[15];
		crcNext[14] = term[2] ^ term[7] ^ term[14];
		crcNext[15] = term[1] ^ term[6] ^ term[13];
	end

	// ****************
	// Checksum register
	// ****************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			crcState <= `CRC_SEED;
		end else if (clkEn) begin
			if (link.burstStart) begin
				crcState <= `CRC_SEED;
			end else if (link.wordStrobe && !link.burstEnd) begin
				crcState <= crcNext;
			end
		end
	end

	// ****************
	// Burst phase
	// ****************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase <= IDLE;
		end else if (clkEn) begin
			unique case (phase)
				IDLE: begin
					if (link.burstStart) begin
						phase <= BURST;
					end
				end
				BURST: begin
					if (link.burstEnd) begin
						phase <= CHECK;
					end
				end
				CHECK: begin
					phase <= link.burstStart ? BURST : IDLE;
				end
				default: begin
					phase <= IDLE;
				end
			endcase
		end
	end

	// ****************
	// Compare and report
	// ****************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			crcError    <= 1'b0;
			errorReport <= 1'b0;
		end else if (clkEn) begin
			errorReport <= 1'b0;
			if (phase == BURST && link.burstEnd &&
				link.busWord != crcState) begin
				crcError <= 1'b1;
			end else if (cmdDone) begin
				crcError <= 1'b0;
			end
			if (cmdDone) begin
				errorReport <= crcError ||
					(phase == BURST && link.burstEnd &&
					link.busWord != crcState);
			end
		end
	end
endmodule // crc_drive_end

// ---- hdl/crc_host_end.sv ----
`timescale 1ns/1ps
module crc_host_end
	import burst_word_crc16_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        clkEn,
	// Link
	crc_link_if.host         link,
	// User side
	input  wire logic        startBurst,
	input  wire logic        wordValid,
	input  wire logic [15:0] wordIn,
	input  wire logic        endBurst,
	output logic      [15:0] crcState
);
`include "burst_word_crc16_consts.svh"
	logic [15:0] busWordQ;
	logic        strobeQ;
	logic        startQ;
	logic        endQ;

	assign link.busWord    = busWordQ;
	assign link.wordStrobe = strobeQ;
	assign link.burstStart = startQ;
	assign link.burstEnd   = endQ;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			crcState <= `CRC_SEED;
		end else if (clkEn) begin
			if (startBurst) begin
				crcState <= `CRC_SEED;
			end else if (wordValid && !endBurst) begin
				crcState <= crc_next_f(crcState, wordIn);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			busWordQ <= 16'h0000;
			strobeQ  <= 1'b0;
			startQ   <= 1'b0;
			endQ     <= 1'b0;
		end else if (clkEn) begin
			startQ  <= startBurst;
			strobeQ <= wordValid && !startBurst && !endBurst;
			endQ    <= endBurst && !startBurst;
			if (endBurst) begin
				busWordQ <= crcState;
			end else begin
				busWordQ <= wordIn;
			end
		end
	end
endmodule // crc_host_end

// ---- hdl/crc_link_if.sv ----
`timescale 1ns/1ps
interface crc_link_if;
	logic [15:0] busWord;
	logic        wordStrobe;
	logic        burstStart;
	logic        burstEnd;
	modport drive (input busWord, wordStrobe, burstStart, burstEnd);
	modport host  (output busWord, wordStrobe, burstStart, burstEnd);
endinterface

// ---- test/burst_word_crc16_tb.sv ----
`timescale 1ns/1ps
module burst_word_crc16_tb;
	import burst_word_crc16_pkg::*;
	logic       clk_sys = 1'b0, reset = 1'b1, endBurst = 1'b0;
	logic       startBurst = 1'b0, wordValid = 1'b0;
	logic       cmdDone = 1'b0, cmdDone2 = 1'b0, clkEn = 1'b1;
	word_t      wordIn = 16'h0000, hostCrc, crcA, crcB;
	logic       errA, repA, errB, repB;
	int         num_errors = 0, compares = 0;
	crc_link_if lk ();
	crc_link_if lk2 ();
	crc_host_end crc_host_end_i (.clk_sys(clk_sys), .reset(reset),
		.clkEn(clkEn), .link(lk), .startBurst(startBurst),
		.wordValid(wordValid), .wordIn(wordIn), .endBurst(endBurst),
		.crcState(hostCrc));
	crc_drive_end crc_drive_end_i (.clk_sys(clk_sys), .reset(reset),
		.clkEn(clkEn), .link(lk), .cmdDone(cmdDone), .crcState(crcA),
		.crcError(errA), .errorReport(repA));
	// Second drive end fed by a faulty host
	crc_drive_end crc_drive_end_i2 (.clk_sys(clk_sys), .reset(reset),
		.clkEn(clkEn), .link(lk2), .cmdDone(cmdDone2), .crcState(crcB),
		.crcError(errB), .errorReport(repB));
	crc_link_checker crc_link_checker_i (.clk_sys(clk_sys), .reset(reset),
		.busWord(lk.busWord), .wordStrobe(lk.wordStrobe),
		.burstStart(lk.burstStart), .burstEnd(lk.burstEnd));
	always #10 clk_sys = ~clk_sys;
	task chk(input word_t seen, input word_t exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task go(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task tally_and_finish;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task host_burst(input word_t w[2], input int n, input word_t exp);
		startBurst = 1'b1;
		go(1);
		startBurst = 1'b0;
		for (int i = 0; i < n; i++) begin
			wordValid = 1'b1;
			wordIn = w[i];
			go(1);
		end
		wordValid = 1'b0;
		endBurst = 1'b1;
		go(1);
		endBurst = 1'b0;
		go(3);
		chk(hostCrc, exp);
		chk(crcA, exp);
		chk(word_t'(errA), 16'h0000);
		cmdDone = 1'b1;
		go(1);
		cmdDone = 1'b0;
		chk(word_t'(repA), 16'h0000);
	endtask
	task freeze_burst;
		startBurst = 1'b1;
		go(1);
		startBurst = 1'b0;
		wordValid = 1'b1;
		wordIn = 16'h5D52;
		clkEn = 1'b0;
		go(2);
		chk(hostCrc, 16'h4ABA);
		chk(crcA, 16'h0000);
		clkEn = 1'b1;
		go(1);
		chk(crcA, 16'h4ABA);
		wordValid = 1'b0;
		endBurst = 1'b1;
		go(1);
		endBurst = 1'b0;
		go(3);
		chk(hostCrc, 16'h0000);
		chk(crcA, 16'h0000);
		chk(word_t'(errA), 16'h0000);
	endtask
	task fault_burst;
		lk2.burstStart = 1'b1;
		go(1);
		lk2.burstStart = 1'b0;
		lk2.wordStrobe = 1'b1;
		lk2.busWord = 16'h5D52;
		go(1);
		// Strobe left high on the end cycle
		lk2.burstEnd = 1'b1;
		lk2.busWord = 16'h0001;
		go(1);
		lk2.burstEnd = 1'b0;
		lk2.wordStrobe = 1'b0;
		lk2.busWord = 16'hFFFE;
		go(1);
		chk(crcB, 16'h0000);
		chk(word_t'(errB), 16'h0001);
		cmdDone2 = 1'b1;
		go(1);
		cmdDone2 = 1'b0;
		chk(word_t'(repB), 16'h0001);
		chk(word_t'(errB), 16'h0000);
	endtask
	initial begin
		lk2.busWord = 16'h0000;
		lk2.wordStrobe = 1'b0;
		lk2.burstStart = 1'b0;
		lk2.burstEnd = 1'b0;
		go(10);
		reset = 1'b0;
		host_burst('{16'h0000, 16'h0000}, 0, 16'h4ABA);
		host_burst('{16'h5D52, 16'h0001}, 2, 16'h1B98);
		host_burst('{16'h5D52, 16'h8001}, 2, 16'h0BB9);
		host_burst('{16'h5D52, 16'h0000}, 1, 16'h0000);
		freeze_burst;
		fault_burst;
		tally_and_finish;
	end
	initial begin
		#20us;
		num_errors++;
		tally_and_finish;
	end
endmodule // burst_word_crc16_tb

// ---- test/crc_link_checker.sv ----
`timescale 1ns/1ps
module crc_link_checker (
	// Clock, reset and link signals
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [15:0] busWord,
	input wire logic        wordStrobe,
	input wire logic        burstStart,
	input wire logic        burstEnd
);
	one_pulse_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$onehot0({burstStart, wordStrobe, burstEnd})) else $error("pulses overlap");
	reset_quiet_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$fell(reset) |-> !(burstStart | wordStrobe | burstEnd))
		else $error("link busy after reset");
	empty_seed_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		burstEnd && $past(burstStart) |-> busWord == 16'h4ABA)
		else $error("empty burst checksum wrong");
	strobe_in_burst_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		wordStrobe |-> $past(burstStart) || $past(wordStrobe))
		else $error("data strobe outside burst");
	end_single_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		burstEnd |=> !burstEnd)
		else $error("burst end longer than one cycle");
	end_after_data_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		burstEnd |-> $past(wordStrobe) || $past(burstStart))
		else $error("burst end without open burst");
endmodule // crc_link_checker
